//--- core/sic_ctrl.sv
/*
 * Interrupt status, mask and operation mode registers of the switching unit,
 * with the control memory access timer and the pin drive controls.
 * Assumes event inputs are one-cycle pulses or levels from logic on ref_clk;
 * pin inputs (framing, receive data) are synchronised here.
 */
`include "sic_map.svh"
`default_nettype none
module sic_ctrl (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [4:0] addr,
    input wire logic rd_stb,
    input wire logic wr_stb,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    output logic irq_n,
    input wire logic timer_expired,
    input wire logic timer_irq_req,
    input wire logic change_fifo_nonempty,
    input wire logic monitor_cmd_done,
    input wire logic monitor_active_found,
    input wire logic pcm_sync_status_pin,
    input wire logic mismatch_detect,
    input wire logic mismatch_detail_read,
    input wire logic window_open,
    input wire logic sync_chan_enabled,
    input wire logic window_missed,
    input wire logic mem_access_start,
    input wire logic mem_tristate_fill,
    input wire logic [3:0] mem_cmd_hi,
    input wire logic [3:0] txd,
    input wire logic [3:0] rxd_pin,
    output logic [3:0] rxd_int,
    output logic mem_busy,
    output logic mem_all_locations,
    output logic mem_clear_codes,
    output logic if_operational,
    output logic pcm_tx_oe,
    output logic tristate_ctrl_force_high,
    output logic cfi_oe,
    output logic cfi_open_drain,
    output logic monitor_handshake_en,
    output logic bank_sel_hi
);
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] mask;
        logic [7:0] mode;
        logic [7:0] rd_data;
        logic irq_n;
        logic [1:0] gap;
        logic mis_armed;
        logic pss_s1;
        logic pss_s2;
        logic pss_d;
        logic [3:0] rx_s1;
        logic [3:0] rx_s2;
        logic [3:0] rxd_int;
        sic_pkg::sic_acc_t acc;
        logic [11:0] cnt;
        logic mem_all;
        logic mem_clr;
        logic if_op;
        logic pcm_oe;
        logic tsc_hi;
        logic cfi_oe;
        logic cfi_od;
        logic hs_en;
        logic bank;
    } sic_state_t;

    sic_state_t cur_ff;
    sic_state_t nxt_s;
    logic [7:0] ev;
    logic [4:0] eff_addr;
    logic st_rd;
    logic [7:0] nxt_status;
    logic [7:0] nxt_mask;
    sic_pkg::sic_mode_t md;

    function automatic logic [11:0] acc_cycles(input logic [1:0] m,
                                               input logic fill);
        logic [11:0] c;
        c = `SIC_NORM_CYC;
        unique case (m)
            2'b00: c = `SIC_RESET_CYC;
            2'b01: c = `SIC_TEST_CYC;
            2'b10: c = `SIC_INIT_CYC;
            2'b11: c = fill ? `SIC_TRI_CYC : `SIC_NORM_CYC;
        endcase
        return c;
    endfunction

    assign md = sic_pkg::sic_mode_t'(cur_ff.mode[7:6]);

    always_comb begin
        nxt_s = cur_ff;
        eff_addr = addr;
        eff_addr[`SIC_BANK_ADDR_BIT] = addr[`SIC_BANK_ADDR_BIT] |
            cur_ff.mode[`SIC_MODE_RBS];
        st_rd = rd_stb && eff_addr == `SIC_STATUS_OFS;
        ev = 8'h00;
        ev[`SIC_BIT_TIN] = timer_expired && timer_irq_req;
        ev[`SIC_BIT_MON] = monitor_cmd_done;
        ev[`SIC_BIT_ACT] = monitor_active_found;
        ev[`SIC_BIT_PFR] = cur_ff.pss_s2 != cur_ff.pss_d;
        ev[`SIC_BIT_MIS] = mismatch_detect && cur_ff.mis_armed;
        ev[`SIC_BIT_WIN] = window_open && sync_chan_enabled;
        ev[`SIC_BIT_OVF] = window_missed;
        nxt_s.pss_s1 = pcm_sync_status_pin;
        nxt_s.pss_s2 = cur_ff.pss_s1;
        nxt_s.pss_d = cur_ff.pss_s2;
        if (ev[`SIC_BIT_MIS])
            nxt_s.mis_armed = 1'b0;
        else if (mismatch_detail_read)
            nxt_s.mis_armed = 1'b1;
        // Read clears only the visible unmasked bits; set wins over clear
        nxt_status = cur_ff.status;
        if (st_rd)
            nxt_status = cur_ff.status & cur_ff.mask;
        nxt_status = nxt_status | ev;
        nxt_status[`SIC_BIT_SIG] = change_fifo_nonempty;
        nxt_s.status = nxt_status;
        nxt_mask = cur_ff.mask;
        nxt_s.rd_data = 8'h00;
        if (st_rd) begin
            nxt_s.rd_data = cur_ff.status & ~cur_ff.mask;
            nxt_s.rd_data[`SIC_BIT_SIG] = cur_ff.status[`SIC_BIT_SIG];
        end else if (rd_stb && eff_addr == `SIC_MODE_OFS) begin
            nxt_s.rd_data = cur_ff.mode;
        end
        nxt_s.gap = (cur_ff.gap != 2'd0) ? cur_ff.gap - 2'd1 : 2'd0;
        if (wr_stb && eff_addr == `SIC_MASK_OFS) begin
            nxt_mask = wr_data;
            if (|(cur_ff.status & ~cur_ff.mask))
                nxt_s.gap = `SIC_GAP_CYC;
        end
        nxt_s.mask = nxt_mask;
        if (wr_stb && eff_addr == `SIC_MODE_OFS)
            nxt_s.mode = wr_data;
        nxt_s.irq_n = !((|(nxt_status & ~nxt_mask &
            ~(8'h01 << `SIC_BIT_SIG))) ||
            (nxt_status[`SIC_BIT_SIG] && !nxt_mask[`SIC_BIT_SIG])) ||
            nxt_s.gap != 2'd0;
        nxt_s.rx_s1 = rxd_pin;
        nxt_s.rx_s2 = cur_ff.rx_s1;
        nxt_s.rxd_int = cur_ff.mode[`SIC_MODE_PTL] ? txd : cur_ff.rx_s2;
        unique case (cur_ff.acc)
            sic_pkg::SIC_IDLE: begin
                if (mem_access_start) begin
                    nxt_s.acc = sic_pkg::SIC_BUSY;
                    nxt_s.cnt = acc_cycles(cur_ff.mode[7:6],
                        mem_tristate_fill);
                    nxt_s.mem_all = md == sic_pkg::SIC_TEST ||
                        md == sic_pkg::SIC_CM_RESET;
                    nxt_s.mem_clr = md == sic_pkg::SIC_CM_RESET &&
                        mem_cmd_hi == `SIC_CLEAR_CMD_HI;
                end
            end
            sic_pkg::SIC_BUSY: begin
                nxt_s.cnt = cur_ff.cnt - 12'd1;
                if (cur_ff.cnt <= 12'd1) begin
                    nxt_s.acc = sic_pkg::SIC_IDLE;
                    nxt_s.mem_all = 1'b0;
                    nxt_s.mem_clr = 1'b0;
                end
            end
            default: nxt_s.acc = sic_pkg::SIC_IDLE;
        endcase
        nxt_s.if_op = cur_ff.mode[7:6] == 2'b11 ||
            cur_ff.mode[7:6] == 2'b01;
        nxt_s.pcm_oe = nxt_s.if_op && cur_ff.mode[`SIC_MODE_PSB];
        nxt_s.tsc_hi = !cur_ff.mode[`SIC_MODE_PSB];
        nxt_s.cfi_oe = nxt_s.if_op && cur_ff.mode[`SIC_MODE_CSB];
        nxt_s.cfi_od = cur_ff.mode[`SIC_MODE_COS];
        nxt_s.hs_en = cur_ff.mode[`SIC_MODE_MONITOR_PROTOCOL_SELECT];
        nxt_s.bank = cur_ff.mode[`SIC_MODE_RBS];
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cur_ff <= '0;
            cur_ff.status <= `SIC_STATUS_RST;
            cur_ff.mask <= `SIC_MASK_RST;
            cur_ff.mode <= `SIC_MODE_RST;
            cur_ff.irq_n <= 1'b1;
            cur_ff.mis_armed <= 1'b1;
            cur_ff.tsc_hi <= 1'b1;
        end else if (clk_en) begin
            cur_ff <= nxt_s;
        end
    end

    assign rd_data = cur_ff.rd_data;
    assign irq_n = cur_ff.irq_n;
    assign rxd_int = cur_ff.rxd_int;
    assign mem_busy = cur_ff.acc[0];
    assign mem_all_locations = cur_ff.mem_all;
    assign mem_clear_codes = cur_ff.mem_clr;
    assign if_operational = cur_ff.if_op;
    assign pcm_tx_oe = cur_ff.pcm_oe;
    assign tristate_ctrl_force_high = cur_ff.tsc_hi;
    assign cfi_oe = cur_ff.cfi_oe;
    assign cfi_open_drain = cur_ff.cfi_od;
    assign monitor_handshake_en = cur_ff.hs_en;
    assign bank_sel_hi = cur_ff.bank;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);

    timer_flag_set_a: assert property (
        clk_en && timer_expired && timer_irq_req |=>
        cur_ff.status[`SIC_BIT_TIN])
        else $error("timer flag not set");
    sig_follow_a: assert property (
        clk_en |=> cur_ff.status[`SIC_BIT_SIG] == $past(change_fifo_nonempty))
        else $error("signaling flag not following fifo");
    mon_done_a: assert property (
        clk_en && monitor_cmd_done |=> cur_ff.status[`SIC_BIT_MON])
        else $error("monitor done flag not set");
    frame_toggle_a: assert property (
        clk_en && cur_ff.pss_s2 != cur_ff.pss_d |=>
        cur_ff.status[`SIC_BIT_PFR])
        else $error("framing flag missed toggle");
    mis_block_a: assert property (
        clk_en && !cur_ff.mis_armed && !mismatch_detail_read && st_rd &&
        !cur_ff.mask[`SIC_BIT_MIS] |=> !cur_ff.status[`SIC_BIT_MIS])
        else $error("mismatch flag not suppressed");
    win_gate_a: assert property (
        clk_en && st_rd && !cur_ff.mask[`SIC_BIT_WIN] && !window_open |=>
        !cur_ff.status[`SIC_BIT_WIN])
        else $error("window flag not cleared on read");
    mask_hold_a: assert property (
        clk_en && st_rd && cur_ff.mask[`SIC_BIT_OVF] &&
        cur_ff.status[`SIC_BIT_OVF] |=> cur_ff.status[`SIC_BIT_OVF])
        else $error("masked event lost on read");
    mask_gap_a: assert property (
        clk_en && wr_stb && eff_addr == `SIC_MASK_OFS &&
        |(cur_ff.status & ~cur_ff.mask) |=> irq_n)
        else $error("no inactive gap on mask write");
    reset_time_a: assert property (
        clk_en && cur_ff.acc == sic_pkg::SIC_IDLE && mem_access_start &&
        md == sic_pkg::SIC_CM_RESET |=> cur_ff.cnt == 12'd256)
        else $error("reset mode access count wrong");
    loop_a: assert property (
        clk_en && cur_ff.mode[`SIC_MODE_PTL] |=> rxd_int == $past(txd))
        else $error("test loop not feeding back");
    act_found_a: assert property (
        clk_en && monitor_active_found |=> cur_ff.status[`SIC_BIT_ACT])
        else $error("active found flag not set");
    mis_set_a: assert property (
        clk_en && mismatch_detect && cur_ff.mis_armed |=>
        cur_ff.status[`SIC_BIT_MIS])
        else $error("mismatch flag not set");
    win_block_a: assert property (
        clk_en && !sync_chan_enabled && !st_rd |=>
        $stable(cur_ff.status[`SIC_BIT_WIN]))
        else $error("window flag set with no channel");
    ovf_set_a: assert property (
        clk_en && window_missed |=> cur_ff.status[`SIC_BIT_OVF])
        else $error("overflow flag not set");
    mask_write_a: assert property (
        clk_en && wr_stb && eff_addr == `SIC_MASK_OFS |=>
        cur_ff.mask == $past(wr_data))
        else $error("mask write lost");
    sig_show_a: assert property (
        clk_en && st_rd |=>
        rd_data[`SIC_BIT_SIG] == $past(cur_ff.status[`SIC_BIT_SIG]))
        else $error("signaling flag hidden on read");
    irq_on_a: assert property (
        cur_ff.gap == 2'd0 && |(cur_ff.status & ~cur_ff.mask) |-> !irq_n)
        else $error("interrupt missing for unmasked flag");
    irq_off_a: assert property (
        !(|(cur_ff.status & ~cur_ff.mask)) |-> irq_n)
        else $error("interrupt with no unmasked flag");
    standby_a: assert property (
        clk_en && !cur_ff.mode[`SIC_MODE_PSB] |=>
        !pcm_tx_oe && tristate_ctrl_force_high)
        else $error("standby drive wrong");
    driver_sel_a: assert property (
        clk_en |=> cfi_open_drain == $past(cur_ff.mode[`SIC_MODE_COS]))
        else $error("driver type wrong");
    hs_sel_a: assert property (
        clk_en |=>
        monitor_handshake_en == $past(cur_ff.mode[`SIC_MODE_MONITOR_PROTOCOL_SELECT]))
        else $error("handshake select wrong");
    cfi_float_a: assert property (
        clk_en && !cur_ff.mode[`SIC_MODE_CSB] |=> !cfi_oe)
        else $error("cfi outputs not floated");
    bank_or_a: assert property (
        clk_en && rd_stb && cur_ff.mode[`SIC_MODE_RBS] |=>
        rd_data == 8'h00)
        else $error("bank select not applied");
    init_time_a: assert property (
        clk_en && cur_ff.acc == sic_pkg::SIC_IDLE && mem_access_start &&
        md == sic_pkg::SIC_CM_INIT |=> cur_ff.cnt == 12'd2)
        else $error("init mode access count wrong");
    norm_time_a: assert property (
        clk_en && cur_ff.acc == sic_pkg::SIC_IDLE && mem_access_start &&
        md == sic_pkg::SIC_NORMAL && !mem_tristate_fill |=>
        cur_ff.cnt == 12'd9)
        else $error("normal access count wrong");
    fill_time_a: assert property (
        clk_en && cur_ff.acc == sic_pkg::SIC_IDLE && mem_access_start &&
        md == sic_pkg::SIC_NORMAL && mem_tristate_fill |=>
        cur_ff.cnt == 12'd1035)
        else $error("tristate fill count wrong");
    test_all_a: assert property (
        clk_en && cur_ff.acc == sic_pkg::SIC_IDLE && mem_access_start &&
        md == sic_pkg::SIC_TEST |=>
        mem_all_locations && cur_ff.cnt == 12'd2057)
        else $error("test mode access wrong");
    clear_cmd_a: assert property (
        clk_en && cur_ff.acc == sic_pkg::SIC_IDLE && mem_access_start &&
        md == sic_pkg::SIC_CM_RESET && mem_cmd_hi == `SIC_CLEAR_CMD_HI |=>
        mem_clear_codes)
        else $error("clear command not flagged");
    reset_off_a: assert property (
        clk_en && cur_ff.mode[7:6] == 2'b00 |=>
        !if_operational && !pcm_tx_oe && !cfi_oe)
        else $error("interfaces active in reset mode");
    freeze_a: assert property (
        !clk_en |=> $stable(cur_ff))
        else $error("state moved while disabled");

    irq_cov_c: cover property (clk_en && !irq_n);
    gap_cov_c: cover property (clk_en && cur_ff.gap == `SIC_GAP_CYC);
    acc_cov_c: cover property (mem_busy ##1 !mem_busy);
    win_cov_c: cover property (clk_en && window_open && !sync_chan_enabled);
    mis_cov_c: cover property (clk_en && mismatch_detect && !cur_ff.mis_armed);
endmodule
`default_nettype wire

//--- core/sic_map.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * switching unit's interrupt and operation mode logic.
 * Assumes a 50 MHz reference clock and a five-bit register address.
 */
`ifndef SIC_MAP_SVH
`define SIC_MAP_SVH

`define SIC_ADDR_W 5
`define SIC_STATUS_OFS 5'h0e
`define SIC_MASK_OFS 5'h0e
`define SIC_MODE_OFS 5'h0f
`define SIC_BANK_ADDR_BIT 4

`define SIC_STATUS_RST 8'h00
`define SIC_MASK_RST 8'h00
`define SIC_MODE_RST 8'h00

`define SIC_BIT_TIN 7
`define SIC_BIT_SIG 6
`define SIC_BIT_MON 5
`define SIC_BIT_ACT 4
`define SIC_BIT_PFR 3
`define SIC_BIT_MIS 2
`define SIC_BIT_WIN 1
`define SIC_BIT_OVF 0

`define SIC_MODE_OMS_HI 7
`define SIC_MODE_OMS_LO 6
`define SIC_MODE_PSB 5
`define SIC_MODE_PTL 4
`define SIC_MODE_COS 3
`define SIC_MODE_MONITOR_PROTOCOL_SELECT 2
`define SIC_MODE_CSB 1
`define SIC_MODE_RBS 0

// Access times in half reference clock cycles, as printed
`define SIC_RESET_HALF 12'd512
`define SIC_INIT_HALF 12'd5
`define SIC_NORM_HALF 12'd19
`define SIC_TRI_HALF 12'd2070
`define SIC_TEST_HALF 13'd4114
// Cycles: odd times (init, normal) round down, at least one cycle
`define SIC_RESET_CYC 12'((`SIC_RESET_HALF) / 2)
`define SIC_INIT_CYC 12'((`SIC_INIT_HALF) / 2)
`define SIC_NORM_CYC 12'((`SIC_NORM_HALF) / 2)
`define SIC_TRI_CYC 12'((`SIC_TRI_HALF) / 2)
`define SIC_TEST_CYC 12'((`SIC_TEST_HALF) / 2)
// Interrupt output held inactive after a mask write made while an unmasked flag is set
`define SIC_GAP_CYC 2'd2
`define SIC_CLEAR_CMD_HI 4'h7

`endif

//--- core/sic_pkg.sv
/*
 * Types of the switching unit's interrupt and operation mode logic.
 * Assumes sic_map.svh supplies the numbers.
 */
`default_nettype none
package sic_pkg;
    typedef enum logic [1:0] {
        SIC_CM_RESET = 2'b00,
        SIC_TEST = 2'b01,
        SIC_CM_INIT = 2'b10,
        SIC_NORMAL = 2'b11
    } sic_mode_t;

    typedef enum logic [1:0] {
        SIC_IDLE = 2'b00,
        SIC_BUSY = 2'b01
    } sic_acc_t;
endpackage
`default_nettype wire

//--- verif/sic_host.sv
/*
 * Host processor model on the register strobe bus.
 * Assumes the bench calls wr and rd at a falling edge of ref_clk.
 */
`default_nettype none
module sic_host (
    input wire logic ref_clk,
    output logic [4:0] addr,
    output logic rd_stb,
    output logic wr_stb,
    output logic [7:0] wr_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] exp_q[$];
    initial begin
        addr = 5'h00;
        rd_stb = 1'b0;
        wr_stb = 1'b0;
        wr_data = 8'h00;
    end
    // Released bus lines are inverted once so stale values never pass
    task automatic rel();
        addr = ~addr;
        wr_data = ~wr_data;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        addr = a;
        wr_data = d;
        wr_stb = 1'b1;
        @(negedge ref_clk);
        wr_stb = 1'b0;
        rel();
        @(negedge ref_clk);
    endtask
    // Notes the expected byte, then reads; a status read clears flags
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        addr = a;
        rd_stb = 1'b1;
        @(negedge ref_clk);
        rd_stb = 1'b0;
        rel();
        @(negedge ref_clk);
    endtask
endmodule
`default_nettype wire

//--- verif/tb.sv
/*
 * Self-checking bench of the status, mask and mode registers.
 * Assumes sic_map.svh offsets and a 50 MHz ref_clk.
 */
`include "sic_map.svh"
`default_nettype none
`define CHK(g, e) cmp(16'(g), 16'(e))
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic tmr = 1'b0, treq = 1'b0, fifo = 1'b0, mdone = 1'b0, mact = 1'b0;
    logic pcm_sync_status = 1'b0, mism = 1'b0, mrd = 1'b0, wopen = 1'b0, schan = 1'b0;
    logic wmiss = 1'b0, mstart = 1'b0, tfill = 1'b0, ce = 1'b1;
    logic [3:0] cmd_hi = 4'h0, txd = 4'h0, rxd_pin = 4'h0;
    logic [4:0] addr;
    logic rd_stb, wr_stb, irq_n, busy, all_loc, clr, if_op, pcm_oe, tsc_hi;
    logic cfi_oe, cfi_od, hs_en, bank_hi, rv = 1'b0;
    logic [7:0] wr_data, rd_data;
    logic [3:0] rxd_int;
    int error_cnt = 0, total_checks = 0, cyc = 0;
    localparam logic [7:0] EVB [6] = '{8'h01, 8'h02, 8'h04, 8'h10, 8'h20,
        8'h80};
    always #10 ref_clk = ~ref_clk;
    sic_host u_host (.ref_clk(ref_clk), .addr(addr), .rd_stb(rd_stb),
        .wr_stb(wr_stb), .wr_data(wr_data));
    sic_ctrl u_dut (.ref_clk(ref_clk), .srst(srst), .clk_en(ce),
        .addr(addr), .rd_stb(rd_stb), .wr_stb(wr_stb), .wr_data(wr_data),
        .rd_data(rd_data), .irq_n(irq_n), .timer_expired(tmr),
        .timer_irq_req(treq), .change_fifo_nonempty(fifo),
        .monitor_cmd_done(mdone), .monitor_active_found(mact),
        .pcm_sync_status_pin(pcm_sync_status), .mismatch_detect(mism),
        .mismatch_detail_read(mrd), .window_open(wopen),
        .sync_chan_enabled(schan), .window_missed(wmiss),
        .mem_access_start(mstart), .mem_tristate_fill(tfill),
        .mem_cmd_hi(cmd_hi), .txd(txd), .rxd_pin(rxd_pin),
        .rxd_int(rxd_int), .mem_busy(busy), .mem_all_locations(all_loc),
        .mem_clear_codes(clr), .if_operational(if_op), .pcm_tx_oe(pcm_oe),
        .tristate_ctrl_force_high(tsc_hi), .cfi_oe(cfi_oe),
        .cfi_open_drain(cfi_od), .monitor_handshake_en(hs_en),
        .bank_sel_hi(bank_hi));
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        rv <= rd_stb;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end
    // Takes the oldest noted read value when read data appears
    always @(negedge ref_clk) begin
        if (rv && u_host.exp_q.size() > 0) begin
            `CHK(rd_data, u_host.exp_q.pop_front());
        end
    end
    task automatic fire(input int k);
        {tmr, mdone, mact, mism, wopen, wmiss} = 6'(1 << k);
        @(negedge ref_clk);
        {tmr, mdone, mact, mism, wopen, wmiss} = 6'h00;
        @(negedge ref_clk);
    endtask
    task automatic rs(input logic [7:0] e);
        u_host.rd(`SIC_STATUS_OFS, e);
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic mem_run(input logic [7:0] m, input logic f, input int n);
        int c;
        c = 0;
        tfill = f;
        u_host.wr(`SIC_MODE_OFS, m);
        mstart = 1'b1;
        @(negedge ref_clk);
        mstart = 1'b0;
        `CHK(all_loc, m[7:6] == 2'b01 || m[7:6] == 2'b00);
        `CHK(clr, m[7:6] == 2'b00 && cmd_hi == 4'h7);
        `CHK(if_op, m[6]);
        while (busy === 1'b1 && c < 3000) begin
            c++;
            @(negedge ref_clk);
        end
        `CHK(c, n);
    endtask
    initial begin
        void'($urandom(15368));
        wt(8);
        `CHK(irq_n, 1'b1);
        `CHK(tsc_hi, 1'b1);
        srst = 1'b0;
        rs(`SIC_STATUS_RST);
        u_host.rd(`SIC_MODE_OFS, `SIC_MODE_RST);
        u_host.rd(5'h03, 8'h00);
        treq = 1'b1;
        schan = 1'b1;
        // Each of the six pulsed sources sets, interrupts, clears on read; the mismatch flag then stays disarmed
        for (int k = 0; k < 6; k++) begin
            fire(k);
            `CHK(irq_n, 1'b0);
            rs(EVB[k]);
            rs(8'h00);
            `CHK(irq_n, 1'b1);
        end
        fire(2);
        rs(8'h00);
        mrd = 1'b1;
        wt(1);
        mrd = 1'b0;
        fire(2);
        rs(8'h04);
        treq = 1'b0;
        schan = 1'b0;
        fire(5);
        fire(1);
        rs(8'h00);
        treq = 1'b1;
        pcm_sync_status = 1'b1;
        wt(6);
        rs(8'h08);
        pcm_sync_status = 1'b0;
        wt(6);
        rs(8'h08);
        fifo = 1'b1;
        wt(2);
        rs(8'h40);
        u_host.wr(`SIC_MASK_OFS, 8'h40);
        wt(3);
        `CHK(irq_n, 1'b1);
        rs(8'h40);
        fifo = 1'b0;
        wt(2);
        rs(8'h00);
        u_host.wr(`SIC_MASK_OFS, 8'hff);
        fire(5);
        `CHK(irq_n, 1'b1);
        rs(8'h00);
        u_host.wr(`SIC_MASK_OFS, 8'h00);
        rs(8'h80);
        fire(5);
        u_host.wr(`SIC_MASK_OFS, 8'h01);
        `CHK(irq_n, 1'b1);
        wt(3);
        `CHK(irq_n, 1'b0);
        rs(8'h80);
        ce = 1'b0;
        fire(4);
        ce = 1'b1;
        rs(8'h00);
        fire(0);
        `CHK(irq_n, 1'b1);
        rs(8'h00);
        u_host.wr(`SIC_MASK_OFS, 8'h00);
        rs(8'h01);
        cmd_hi = `SIC_CLEAR_CMD_HI;
        mem_run(8'h00, 1'b0, 256);
        cmd_hi = 4'h0;
        mem_run(8'h80, 1'b0, 2);
        mem_run(8'hc0, 1'b0, 9);
        mem_run(8'hc0, 1'b1, 1035);
        mem_run(8'h40, 1'b0, 2057);
        u_host.wr(`SIC_MODE_OFS, 8'h3e);
        wt(2);
        `CHK({if_op, cfi_oe, pcm_oe}, 3'b000);
        txd = 4'($urandom);
        rxd_pin = ~txd;
        u_host.wr(`SIC_MODE_OFS, 8'hc0);
        wt(2);
        `CHK({pcm_oe, tsc_hi, cfi_oe, cfi_od, hs_en}, 5'b01000);
        `CHK(rxd_int, rxd_pin);
        u_host.wr(`SIC_MODE_OFS, 8'hfe);
        wt(5);
        `CHK({pcm_oe, tsc_hi, cfi_oe, cfi_od, hs_en}, 5'b10111);
        `CHK(rxd_int, txd);
        u_host.rd(`SIC_MODE_OFS, 8'hfe);
        u_host.wr(`SIC_MODE_OFS, 8'hff);
        wt(2);
        `CHK(bank_hi, 1'b1);
        u_host.rd(`SIC_MODE_OFS, 8'h00);
        wt(3);
        close_out();
    end
endmodule
`default_nettype wire
